//--- shared/irqfec_pkg.sv
package irqfec_pkg;

    // ------------------------------------------------------------
    // register indices (data memory offsets within the block)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_HALL_EDGE  = 4'h0;
    localparam logic [3:0] ADDR_EXT_EDGE   = 4'h1;
    localparam logic [3:0] ADDR_CTRL_A     = 4'h2;
    localparam logic [3:0] ADDR_CTRL_B     = 4'h3;
    localparam logic [3:0] ADDR_CTRL_C     = 4'h4;
    localparam logic [3:0] ADDR_CTRL_D     = 4'h5;
    localparam logic [3:0] ADDR_GRP_BASE   = 4'h6;
    localparam int         NUM_GROUPS      = 7;

    // ------------------------------------------------------------
    // implemented-bit masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_HALL_EDGE  = 8'h7f;
    localparam logic [7:0] MASK_EXT_EDGE   = 8'h03;
    localparam logic [7:0] MASK_CTRL_A     = 8'h7f;
    localparam logic [7:0] MASK_FULL       = 8'hff;
    localparam logic [7:0] MASK_GRP_HALL   = 8'h77;
    localparam logic [7:0] MASK_GRP_TMR    = 8'h33;
    localparam logic [7:0] MASK_GRP_I2C    = 8'h77;
    localparam logic [7:0] RESET_VALUE     = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int HSEL_BIT     = 6;
    localparam int HC_SEL_LSB   = 4;
    localparam int HB_SEL_LSB   = 2;
    localparam int HA_SEL_LSB   = 0;
    localparam int EXT_SEL_LSB  = 0;
    // control a
    localparam int CMP0_F_BIT   = 6;
    localparam int EXT_F_BIT    = 5;
    localparam int G0_F_BIT     = 4;
    localparam int CMP0_E_BIT   = 3;
    localparam int EXT_E_BIT    = 2;
    localparam int G0_E_BIT     = 1;
    localparam int GIE_BIT      = 0;
    // control b
    localparam int OC_F_BIT     = 7;
    localparam int LV_F_BIT     = 6;
    localparam int G1_F_BIT     = 5;
    localparam int NF_F_BIT     = 4;
    localparam int OC_E_BIT     = 3;
    localparam int LV_E_BIT     = 2;
    localparam int G1_E_BIT     = 1;
    localparam int NF_E_BIT     = 0;
    // control c: groups 2..5, flags at 4+k, enables at k
    localparam int CC_F_LSB     = 4;
    // control d
    localparam int TB_F_BIT     = 7;
    localparam int G6_F_BIT     = 6;
    localparam int EE_F_BIT     = 5;
    localparam int UR_F_BIT     = 4;
    localparam int TB_E_BIT     = 3;
    localparam int G6_E_BIT     = 2;
    localparam int EE_E_BIT     = 1;
    localparam int UR_E_BIT     = 0;
    // group registers: flag nibble above enable nibble
    localparam int GRP_F_LSB    = 4;

    localparam logic [1:0] EDGE_OFF     = 2'h0;
    localparam logic [1:0] EDGE_RISE    = 2'h1;
    localparam logic [1:0] EDGE_FALL    = 2'h2;
    localparam logic [1:0] EDGE_BOTH    = 2'h3;

endpackage : irqfec_pkg

//--- verilog/irqfec_top.sv
// Overview of operation
// [RULE1] source bit picks hall pins or comparators
// [RULE2] hall c edge field: off/rise/fall/both
// [RULE3] hall b edge field, same encoding
// [RULE4] hall a edge field, same encoding
// [RULE5] external pin edge field, same encoding
// [RULE6] global enable gates every interrupt
// [RULE7] comparator 0 flag and enable, read/write
// [RULE8] external pin flag on edge, enable
// [RULE9] group 0 flag and enable in ctrl a
// [RULE10] overcurrent flag and enable, read/write
// [RULE11] low voltage flag and enable, read/write
// [RULE12] group 1 flag and enable in ctrl b
// [RULE13] filtered pin flag and enable
// [RULE14] seven groups each with flag, enable
// [RULE15] hall channels flag/enable in group 0
// [RULE16] unimplemented bits read zero, ignore writes
// [RULE17] software clears hall flags itself
// [RULE18] timebase pair sits in ctrl d
// [RULE19] pwm period pair in group register
// [RULE20] flags set regardless of enable
// [RULE21] group flag from enabled sub-flags
// [RULE22] edges found against previous sample
`timescale 1ns/1ns

module irqfec_top
    import irqfec_pkg::*;
(
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    // data memory access
    input  wire logic [3:0]  i_addr,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [7:0]  i_wdata,
    output logic      [7:0]  o_rdata,
    // event sources
    input  wire logic [2:0]  i_hall_input_pins,
    input  wire logic [2:0]  i_hall_comparator_outputs,
    input  wire logic        i_ext_pin,
    input  wire logic        i_cmp0_event,
    input  wire logic        i_filtered_input_pin_event,
    input  wire logic        i_low_volt_event,
    input  wire logic        i_overcurrent_protect,
    input  wire logic        i_timebase_event,
    input  wire logic        i_eeprom_event,
    input  wire logic        i_uart_event,
    input  wire logic [2:0]  i_grp1_events,
    input  wire logic [3:0]  i_pwm_events,
    input  wire logic [1:0]  i_tmr2_events,
    input  wire logic [1:0]  i_tmr0_events,
    input  wire logic [1:0]  i_tmr1_events,
    input  wire logic [2:0]  i_grp6_events,
    // core request
    output logic             o_irq
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic edge_hit(input logic [1:0] sel, input logic cur,
                                      input logic prev);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = ~cur & prev;
        case (sel)
            EDGE_RISE: edge_hit = rise;
            EDGE_FALL: edge_hit = fall;
            EDGE_BOTH: edge_hit = rise | fall;
            default:   edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    // new = set-wins merge of write value and hardware set bits
    function automatic logic [7:0] merge(input logic [7:0] cur, input logic wr,
                                         input logic [7:0] wv, input logic [7:0] set,
                                         input logic [7:0] mask);
        logic [7:0] base;
        base = wr ? wv : cur;
        merge = (base | set) & mask;
    endfunction : merge

    function automatic logic [7:0] grp_mask(input int g);
        if (g == 0)
            grp_mask = MASK_GRP_HALL;
        else if (g == 6)
            grp_mask = MASK_GRP_I2C;
        else if (g == 1 || g == 2)
            grp_mask = MASK_FULL;
        else
            grp_mask = MASK_GRP_TMR;
    endfunction : grp_mask

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] hall_edge_select_r;
    logic [7:0] ext_pin_edge_select_r;
    logic [7:0] primary_irq_ctrl_a_r;
    logic [7:0] primary_irq_ctrl_b_r;
    logic [7:0] primary_irq_ctrl_c_r;
    logic [7:0] primary_irq_ctrl_d_r;
    logic [7:0] group_r [NUM_GROUPS];
    logic [2:0] hall_prev_r;
    logic       ext_prev_r;
    logic       hall_prime_r;

    logic [2:0] hall_sel;
    logic [2:0] hall_hit;
    logic       ext_hit;
    logic [6:0] grp_pend;
    logic [7:0] grp_set [NUM_GROUPS];

    // ------------------------------------------------------------
    // source select and edge detect
    // ------------------------------------------------------------
    // [RULE1] hall source mux
    assign hall_sel = hall_edge_select_r[HSEL_BIT] ? i_hall_comparator_outputs
                                                   : i_hall_input_pins;

    // [RULE22] previous sample
    // prime flag keeps the first sample after reset from counting as an edge
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            hall_prev_r  <= 3'h0;
            ext_prev_r   <= 1'b0;
            hall_prime_r <= 1'b0;
        end
        else
        begin
            hall_prev_r  <= hall_sel;
            ext_prev_r   <= i_ext_pin;
            hall_prime_r <= 1'b1;
        end
    end

    always_comb
    begin
        // [RULE2] hall c edge
        hall_hit[2] = hall_prime_r & edge_hit(hall_edge_select_r[HC_SEL_LSB +: 2],
                                              hall_sel[2], hall_prev_r[2]);
        // [RULE3] hall b edge
        hall_hit[1] = hall_prime_r & edge_hit(hall_edge_select_r[HB_SEL_LSB +: 2],
                                              hall_sel[1], hall_prev_r[1]);
        // [RULE4] hall a edge
        hall_hit[0] = hall_prime_r & edge_hit(hall_edge_select_r[HA_SEL_LSB +: 2],
                                              hall_sel[0], hall_prev_r[0]);
        // [RULE5] external pin edge
        ext_hit = hall_prime_r & edge_hit(ext_pin_edge_select_r[EXT_SEL_LSB +: 2],
                                          i_ext_pin, ext_prev_r);
    end

    // ------------------------------------------------------------
    // group sub-source set bits (flags in upper nibble)
    // ------------------------------------------------------------
    always_comb
    begin
        // [RULE15] hall flags in group 0
        grp_set[0] = {1'b0, hall_hit, 4'h0};
        // adc end has no source line here, so only software raises it
        grp_set[1] = {i_grp1_events, 1'b0, 4'h0};
        // [RULE19] pwm period and duty flags
        grp_set[2] = {i_pwm_events, 4'h0};
        grp_set[3] = {2'h0, i_tmr2_events, 4'h0};
        grp_set[4] = {2'h0, i_tmr0_events, 4'h0};
        grp_set[5] = {2'h0, i_tmr1_events, 4'h0};
        grp_set[6] = {1'b0, i_grp6_events, 4'h0};
    end

    // [RULE21] enabled sub-flag pending
    always_comb
    begin
        for (int g = 0; g < NUM_GROUPS; g++)
            grp_pend[g] = |(group_r[g][GRP_F_LSB +: 4] & group_r[g][GRP_F_LSB-1:0]);
    end

    // ------------------------------------------------------------
    // group registers
    // ------------------------------------------------------------
    // [RULE14] seven group registers
    // [RULE16] masks drop unimplemented bits
    // [RULE17] no hardware clear of sub-flags
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (int g = 0; g < NUM_GROUPS; g++)
                group_r[g] <= RESET_VALUE;
        end
        else
        begin
            for (int g = 0; g < NUM_GROUPS; g++)
                group_r[g] <= merge(group_r[g],
                                    i_wr && (i_addr == ADDR_GRP_BASE + 4'(g)),
                                    i_wdata, grp_set[g], grp_mask(g));
        end
    end

    // ------------------------------------------------------------
    // edge select registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            hall_edge_select_r    <= RESET_VALUE;
            ext_pin_edge_select_r <= RESET_VALUE;
        end
        else
        begin
            if (i_wr && i_addr == ADDR_HALL_EDGE)
                hall_edge_select_r <= i_wdata & MASK_HALL_EDGE;
            if (i_wr && i_addr == ADDR_EXT_EDGE)
                ext_pin_edge_select_r <= i_wdata & MASK_EXT_EDGE;
        end
    end

    // ------------------------------------------------------------
    // primary control registers
    // ------------------------------------------------------------
    logic [7:0] set_a;
    logic [7:0] set_b;
    logic [7:0] set_c;
    logic [7:0] set_d;

    // [RULE20] flags set independent of enables
    always_comb
    begin
        set_a = 8'h00;
        // [RULE7] comparator 0 flag
        set_a[CMP0_F_BIT] = i_cmp0_event;
        // [RULE8] external pin flag
        set_a[EXT_F_BIT]  = ext_hit;
        // [RULE9] group 0 flag
        set_a[G0_F_BIT]   = grp_pend[0];
        set_b = 8'h00;
        // [RULE10] overcurrent flag
        set_b[OC_F_BIT] = i_overcurrent_protect;
        // [RULE11] low voltage flag
        set_b[LV_F_BIT] = i_low_volt_event;
        // [RULE12] group 1 flag
        set_b[G1_F_BIT] = grp_pend[1];
        // [RULE13] filtered pin flag
        set_b[NF_F_BIT] = i_filtered_input_pin_event;
        set_c = {grp_pend[5:2], 4'h0};
        set_d = 8'h00;
        // [RULE18] timebase flag in ctrl d
        set_d[TB_F_BIT] = i_timebase_event;
        set_d[G6_F_BIT] = grp_pend[6];
        set_d[EE_F_BIT] = i_eeprom_event;
        set_d[UR_F_BIT] = i_uart_event;
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            primary_irq_ctrl_a_r <= RESET_VALUE;
            primary_irq_ctrl_b_r <= RESET_VALUE;
            primary_irq_ctrl_c_r <= RESET_VALUE;
            primary_irq_ctrl_d_r <= RESET_VALUE;
        end
        else
        begin
            primary_irq_ctrl_a_r <= merge(primary_irq_ctrl_a_r,
                                          i_wr && i_addr == ADDR_CTRL_A,
                                          i_wdata, set_a, MASK_CTRL_A);
            primary_irq_ctrl_b_r <= merge(primary_irq_ctrl_b_r,
                                          i_wr && i_addr == ADDR_CTRL_B,
                                          i_wdata, set_b, MASK_FULL);
            primary_irq_ctrl_c_r <= merge(primary_irq_ctrl_c_r,
                                          i_wr && i_addr == ADDR_CTRL_C,
                                          i_wdata, set_c, MASK_FULL);
            primary_irq_ctrl_d_r <= merge(primary_irq_ctrl_d_r,
                                          i_wr && i_addr == ADDR_CTRL_D,
                                          i_wdata, set_d, MASK_FULL);
        end
    end

    // ------------------------------------------------------------
    // interrupt output
    // ------------------------------------------------------------
    logic any_pend;

    always_comb
    begin
        any_pend = (|(primary_irq_ctrl_a_r[CMP0_F_BIT:G0_F_BIT]
                      & primary_irq_ctrl_a_r[CMP0_E_BIT:G0_E_BIT]))
                 | (|(primary_irq_ctrl_b_r[OC_F_BIT:NF_F_BIT]
                      & primary_irq_ctrl_b_r[OC_E_BIT:NF_E_BIT]))
                 | (|(primary_irq_ctrl_c_r[CC_F_LSB +: 4]
                      & primary_irq_ctrl_c_r[CC_F_LSB-1:0]))
                 | (|(primary_irq_ctrl_d_r[TB_F_BIT:UR_F_BIT]
                      & primary_irq_ctrl_d_r[TB_E_BIT:UR_E_BIT]));
    end

    // [RULE6] global enable gate
    // registered so the core sees a clean level; costs one cycle of latency
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_irq <= 1'b0;
        else
            o_irq <= any_pend & primary_irq_ctrl_a_r[GIE_BIT];
    end

    // ------------------------------------------------------------
    // read data, registered one cycle after i_rd
    // ------------------------------------------------------------
    // a write in the same cycle as a read returns the old contents
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_rdata <= RESET_VALUE;
        else if (i_rd)
        begin
            if (i_addr == ADDR_HALL_EDGE)
                o_rdata <= hall_edge_select_r;
            else if (i_addr == ADDR_EXT_EDGE)
                o_rdata <= ext_pin_edge_select_r;
            else if (i_addr == ADDR_CTRL_A)
                o_rdata <= primary_irq_ctrl_a_r;
            else if (i_addr == ADDR_CTRL_B)
                o_rdata <= primary_irq_ctrl_b_r;
            else if (i_addr == ADDR_CTRL_C)
                o_rdata <= primary_irq_ctrl_c_r;
            else if (i_addr == ADDR_CTRL_D)
                o_rdata <= primary_irq_ctrl_d_r;
            else if (i_addr >= ADDR_GRP_BASE && i_addr < ADDR_GRP_BASE + 4'(NUM_GROUPS))
                o_rdata <= group_r[3'(i_addr - ADDR_GRP_BASE)];
            // [RULE16] unmapped reads zero
            else
                o_rdata <= RESET_VALUE;
        end
    end

endmodule : irqfec_top

//--- bench/irqfec_monitor.sv
`timescale 1ns/1ns

module irqfec_monitor
    import irqfec_pkg::*;
(
    // bus side
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic [3:0]  i_addr,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [7:0]  i_wdata,
    input  wire logic [7:0]  o_rdata,
    input  wire logic        o_irq,
    // sources
    input  wire logic        i_cmp0_event,
    input  wire logic        i_overcurrent_protect
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_rd(logic [3:0] a);
        i_rd && i_addr == a;
    endsequence

    sequence s_wr_then_rd(logic [3:0] a);
        i_wr && i_addr == a ##1 !i_wr ##1 (s_rd(a) and !i_wr);
    endsequence

    property p_mask(logic [3:0] a, logic [7:0] m);
        s_rd(a) |=> (o_rdata & ~m) == 8'h00;
    endproperty

    a_unmapped_read_zero:
        assert property (i_rd && i_addr > 4'hc |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_hall_mask_zero:
        assert property (p_mask(ADDR_HALL_EDGE, MASK_HALL_EDGE))
        else $error("hall edge spare bit set");
    a_ext_mask_zero:
        assert property (p_mask(ADDR_EXT_EDGE, MASK_EXT_EDGE))
        else $error("ext edge spare bits set");
    a_ctrla_mask_zero:
        assert property (p_mask(ADDR_CTRL_A, MASK_CTRL_A))
        else $error("ctrl a spare bit set");
    a_rdata_holds:
        assert property (!i_rd |=> $stable(o_rdata))
        else $error("read data moved without read");
    a_ext_readback:
        assert property (s_wr_then_rd(ADDR_EXT_EDGE)
            |=> o_rdata == ($past(i_wdata, 3) & MASK_EXT_EDGE))
        else $error("ext edge readback wrong");
    a_hall_readback:
        assert property (s_wr_then_rd(ADDR_HALL_EDGE)
            |=> o_rdata == ($past(i_wdata, 3) & MASK_HALL_EDGE))
        else $error("hall edge readback wrong");
    a_cmp0_flag_set:
        assert property (i_cmp0_event ##1 !i_wr ##1 s_rd(ADDR_CTRL_A)
            |=> o_rdata[CMP0_F_BIT])
        else $error("cmp0 flag not set");
    a_oc_flag_set:
        assert property (i_overcurrent_protect ##1 !i_wr ##1 s_rd(ADDR_CTRL_B)
            |=> o_rdata[OC_F_BIT])
        else $error("overcurrent flag not set");
    a_gie_off_quiet:
        assert property (i_wr && i_addr == ADDR_CTRL_A && !i_wdata[GIE_BIT] |-> ##2 !o_irq)
        else $error("irq with global enable off");
endmodule : irqfec_monitor

bind irqfec_top irqfec_monitor irqfec_monitor_inst (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr),
    .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_irq(o_irq),
    .i_cmp0_event(i_cmp0_event), .i_overcurrent_protect(i_overcurrent_protect));

//--- bench/irqfec_src_model.sv
`timescale 1ns/1ns

module irqfec_src_model
(
    // clock
    input  wire logic        i_clock,
    // levels and strobes toward the block
    output logic      [2:0]  o_hall_pins,
    output logic      [2:0]  o_hall_cmp,
    output logic             o_ext_pin,
    output logic      [22:0] o_ev
);
    initial
    begin
        o_hall_pins = 3'h0;
        o_hall_cmp = 3'h0;
        o_ext_pin = 1'b0;
        o_ev = 23'h0;
    end

    // a peripheral strobe lasts exactly one clock
    task automatic pulse(input logic [22:0] v);
        @(posedge i_clock);
        o_ev <= v;
        @(posedge i_clock);
        o_ev <= 23'h0;
    endtask : pulse

    // levels then settle three clocks so the sampled edge has landed
    task automatic pins(input logic [2:0] h, input logic [2:0] c, input logic e);
        @(posedge i_clock);
        o_hall_pins <= h;
        o_hall_cmp <= c;
        o_ext_pin <= e;
        repeat (3) @(posedge i_clock);
    endtask : pins
endmodule : irqfec_src_model

//--- bench/tb.sv
`timescale 1ns/1ns

module tb
    import irqfec_pkg::*;
;
    logic        i_clock = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [3:0]  i_addr = 4'h0;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [7:0]  i_wdata = 8'h00;
    logic [7:0]  o_rdata;
    logic        o_irq;
    logic [2:0]  hall_pins;
    logic [2:0]  hall_cmp;
    logic        ext_pin;
    logic [22:0] ev;
    int          miscompares = 0;
    int          total_checks = 0;

    localparam logic [7:0] MK[13] = '{MASK_HALL_EDGE, MASK_EXT_EDGE, MASK_CTRL_A, MASK_FULL,
        MASK_FULL, MASK_FULL, MASK_GRP_HALL, MASK_FULL, MASK_FULL, MASK_GRP_TMR, MASK_GRP_TMR,
        MASK_GRP_TMR, MASK_GRP_I2C};
    localparam logic [3:0] SA[7] = '{ADDR_CTRL_A, ADDR_CTRL_B, ADDR_CTRL_B, ADDR_CTRL_B,
        ADDR_CTRL_D, ADDR_CTRL_D, ADDR_CTRL_D};
    localparam int SF[7] = '{CMP0_F_BIT, NF_F_BIT, LV_F_BIT, OC_F_BIT, TB_F_BIT, EE_F_BIT, UR_F_BIT};
    localparam int SE[7] = '{CMP0_E_BIT, NF_E_BIT, LV_E_BIT, OC_E_BIT, TB_E_BIT, EE_E_BIT, UR_E_BIT};
    localparam int GRP[16] = '{1, 1, 1, 2, 2, 2, 2, 3, 3, 4, 4, 5, 5, 6, 6, 6};
    localparam int FB[16] = '{5, 6, 7, 4, 5, 6, 7, 4, 5, 4, 5, 4, 5, 4, 5, 6};
    localparam logic [3:0] PA[7] = '{ADDR_CTRL_A, ADDR_CTRL_B, ADDR_CTRL_C, ADDR_CTRL_C,
        ADDR_CTRL_C, ADDR_CTRL_C, ADDR_CTRL_D};
    localparam int PF[7] = '{G0_F_BIT, G1_F_BIT, 4, 5, 6, 7, G6_F_BIT};
    localparam int PE[7] = '{G0_E_BIT, G1_E_BIT, 0, 1, 2, 3, G6_E_BIT};

    always #5 i_clock = ~i_clock;

    irqfec_src_model irqfec_src_model_inst (.i_clock(i_clock), .o_hall_pins(hall_pins),
        .o_hall_cmp(hall_cmp), .o_ext_pin(ext_pin), .o_ev(ev));

    irqfec_top irqfec_top_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
        .i_hall_input_pins(hall_pins), .i_hall_comparator_outputs(hall_cmp),
        .i_ext_pin(ext_pin), .i_cmp0_event(ev[0]), .i_filtered_input_pin_event(ev[1]),
        .i_low_volt_event(ev[2]), .i_overcurrent_protect(ev[3]), .i_timebase_event(ev[4]),
        .i_eeprom_event(ev[5]), .i_uart_event(ev[6]), .i_grp1_events(ev[9:7]),
        .i_pwm_events(ev[13:10]), .i_tmr2_events(ev[15:14]), .i_tmr0_events(ev[17:16]),
        .i_tmr1_events(ev[19:18]), .i_grp6_events(ev[22:20]), .o_irq(o_irq));

    // ----------------------------------------
    // bus and compare helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1;
        chk(n, e, o_rdata);
    endtask : rd

    // the request line is registered behind the flags, so allow it to settle
    task automatic irq_is(input logic e);
        repeat (3) @(posedge i_clock);
        #1;
        chk("irq", {7'h00, e}, {7'h00, o_irq});
    endtask : irq_is

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_masks();
        for (int a = 0; a < 16; a++)
            rd(a[3:0], 8'h00, "reset value");
        for (int a = 0; a < 14; a++)
        begin
            wr(a[3:0], 8'hff);
            rd(a[3:0], (a < 13) ? MK[a] : 8'h00, "mask");
        end
        irq_is(1'b1);
        for (int a = 12; a >= 0; a--)
            wr(a[3:0], 8'h00);
        irq_is(1'b0);
    endtask : t_masks

    task automatic t_ext();
        for (int m = 0; m < 4; m++)
        begin
            wr(ADDR_EXT_EDGE, 8'(m));
            irqfec_src_model_inst.pins(3'h0, 3'h0, 1'b1);
            rd(ADDR_CTRL_A, 8'(m % 2) << EXT_F_BIT, "ext rise");
            wr(ADDR_CTRL_A, 8'h00);
            irqfec_src_model_inst.pins(3'h0, 3'h0, 1'b0);
            rd(ADDR_CTRL_A, 8'(m / 2) << EXT_F_BIT, "ext fall");
            wr(ADDR_CTRL_A, 8'h00);
        end
    endtask : t_ext

    task automatic t_hall();
        logic [1:0] ma;
        logic [1:0] mb;
        logic [1:0] mc;
        for (int s = 0; s < 2; s++)
            for (int m = 0; m < 4; m++)
            begin
                ma = 2'(m);
                mb = ma + 2'h1;
                mc = ma + 2'h2;
                wr(ADDR_HALL_EDGE, {1'b0, s[0], mc, mb, ma});
                wr(ADDR_GRP_BASE, 8'h07);
                // the unselected source moves first and must stay silent
                irqfec_src_model_inst.pins({3{s[0]}}, {3{~s[0]}}, 1'b0);
                rd(ADDR_GRP_BASE, 8'h07, "hall unselected");
                irqfec_src_model_inst.pins(3'h7, 3'h7, 1'b0);
                rd(ADDR_GRP_BASE, {1'b0, mc[0], mb[0], ma[0], 4'h7}, "hall rise");
                rd(ADDR_CTRL_A, 8'(|{mc[0], mb[0], ma[0]}) << G0_F_BIT, "group0");
                wr(ADDR_GRP_BASE, 8'h07);
                wr(ADDR_CTRL_A, 8'h00);
                irqfec_src_model_inst.pins({3{~s[0]}}, {3{s[0]}}, 1'b0);
                rd(ADDR_GRP_BASE, 8'h07, "hall unselected");
                irqfec_src_model_inst.pins(3'h0, 3'h0, 1'b0);
                rd(ADDR_GRP_BASE, {1'b0, mc[1], mb[1], ma[1], 4'h7}, "hall fall");
                wr(ADDR_GRP_BASE, 8'h00);
                wr(ADDR_CTRL_A, 8'h00);
            end
    endtask : t_hall

    task automatic t_path(input logic [3:0] a, input int fb, input int eb);
        logic [7:0] fv;
        logic [7:0] ev_v;
        fv = 8'h01 << fb;
        ev_v = fv | (8'h01 << eb);
        rd(a, fv, "flag");
        irq_is(1'b0);
        wr(a, ev_v);
        irq_is(1'b0);
        wr(ADDR_CTRL_A, (a == ADDR_CTRL_A) ? (ev_v | 8'h01) : 8'h01);
        irq_is(1'b1);
        wr(a, 8'h00);
        wr(ADDR_CTRL_A, 8'h00);
        irq_is(1'b0);
    endtask : t_path

    task automatic t_sources();
        logic [3:0] ga;
        for (int k = 0; k < 7; k++)
        begin
            irqfec_src_model_inst.pulse(23'h1 << k);
            t_path(SA[k], SF[k], SE[k]);
        end
        for (int k = 0; k < 16; k++)
        begin
            ga = ADDR_GRP_BASE + 4'(GRP[k]);
            irqfec_src_model_inst.pulse(23'h80 << k);
            rd(ga, 8'h01 << FB[k], "sub flag");
            rd(PA[GRP[k]], 8'h00, "group idle");
            wr(ga, (8'h01 << FB[k]) | (8'h01 << (FB[k] - 4)));
            t_path(PA[GRP[k]], PF[GRP[k]], PE[GRP[k]]);
            wr(ga, 8'h00);
            wr(PA[GRP[k]], 8'h00);
        end
    endtask : t_sources

    initial
    begin
        repeat (50000) @(posedge i_clock);
        miscompares++;
        conclude();
    end

    initial
    begin
        repeat (16) @(posedge i_clock);
        i_rst_n <= 1'b1;
        t_masks();
        t_ext();
        t_hall();
        t_sources();
        conclude();
    end
endmodule : tb
